//--- hdl/pdg_pkg.sv
// package: constants shared by the dac load and gain config block
package pdg_pkg;
  // ===========================================================
  // serial frame layout
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned SAMPLE_BITS   = 10;
  localparam int unsigned SAMPLE_MSB    = 15;
  localparam int unsigned SAMPLE_LSB    = 6;
  localparam int unsigned CNT_W         = 5;
  // ===========================================================
  // command frame: bit 15 read flag, bits 14:8 address, 7:0 data
  localparam int unsigned CMD_RD_BIT    = 15;
  localparam int unsigned ADDR_MSB      = 14;
  localparam int unsigned ADDR_LSB      = 8;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned DATA_W        = 8;
  localparam logic [6:0]  ADDR_FIRST_BLOCK_ENABLE_REGISTER  = 7'h01;
  localparam logic [6:0]  ADDR_GAIN     = 7'h02;
  localparam logic [6:0]  ADDR_FIRST_CONTROL_REGISTER = 7'h03;
  // ===========================================================
  // field positions
  localparam int unsigned EN1_DAC_BIT   = 5;
  localparam int unsigned BAND_BIT      = 3;
  localparam int unsigned FRONT_LSB     = 0;
  localparam int unsigned BACK_LSB      = 2;
  localparam int unsigned GAIN_W        = 2;
  // reset values
  localparam logic [7:0]  FIRST_BLOCK_ENABLE_REGISTER_RST   = 8'h00;
  localparam logic [7:0]  GAIN_RST      = 8'h00;
  localparam logic [7:0]  FIRST_CONTROL_REGISTER_RST  = 8'h00;
  localparam logic [9:0]  SAMPLE_RST    = 10'h000;
  // clk_i edges after reset before frame toggles count again
  localparam logic [2:0]  SYNC_ARM      = 3'h4;
  // front stage codes 0..3 : 0.25, 0.5, 1, 2 V/V
  // back stage codes 0..3  : 1, 4, 16, 64 V/V
  localparam logic [1:0]  FRONT_Q25     = 2'h0;
  localparam logic [1:0]  FRONT_UNITY   = 2'h2;
  // ===========================================================
  // fifo
  localparam int unsigned FIFO_DEPTH    = 4;
  // link states
  typedef enum logic [2:0] {
    PDG_IDLE = 3'b001,
    PDG_SHFT = 3'b010,
    PDG_DONE = 3'b100
  } pdg_state_type;
endpackage : pdg_pkg

//--- hdl/pdg_fifo.sv
// small synchronous fifo, head word read combinationally from storage
`timescale 1ns/1ps
`default_nettype none
module pdg_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  logic             full;
  // ===========================================================
  // handshake: ready while not full, pop on valid and ready
  assign full        = (cnt_q == (AW+1)'(DEPTH));
  assign in_ready_o  = !full;
  assign push        = in_valid_i && !full;
  assign pop         = out_valid_o && out_ready_i;
  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  // pointers and count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // head word comes straight from storage, valid while non-empty
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
endmodule : pdg_fifo
`default_nettype wire

//--- hdl/pdg_dac_load.sv
// dac sample loader, gain and band config, two-wire ook transmitter
// Notes on behaviour
// - front gain stage four codes 0.25 to 2
// - back gain stage four codes 1 to 64
// - first_control_register bit 3 selects receive filter band
// - dac select high routes frames to sample
// - keep first ten bits, drop later ones
// - closing sclk edge after cs rising queues sample, dac output loads on dac_ready_i
// - keying high puts transmitter in high-z
// - dac select low reaches command registers
// - dac mode needs pin and enable bit 5
`timescale 1ns/1ps
`default_nettype none
module pdg_dac_load #(
  parameter int unsigned SAMPLE_W = pdg_pkg::SAMPLE_BITS,
  parameter int unsigned DEPTH    = pdg_pkg::FIFO_DEPTH
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  // serial port, sclk is the link clock
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                din_i,
  input  wire logic                dac_sel_i,
  output logic                     dout_o,
  output logic                     dout_oe_o,
  // dac sample output
  output logic      [SAMPLE_W-1:0] dac_data_o,
  output logic                     dac_update_o,
  input  wire logic                dac_ready_i,
  output logic                     dac_mode_o,
  // analog stage settings
  output logic      [1:0]          front_gain_code_o,
  output logic      [1:0]          back_gain_code_o,
  output logic                     front_attenuate_o,
  output logic                     band_select_bit_o,
  // two-wire transmitter
  input  wire logic                carrier_i,
  input  wire logic                keying_i,
  output logic                     ook_out_o,
  output logic                     ook_oe_o,
  output logic                     sample_drop_o
);
  // ===========================================================
  // link domain: shift register on sclk rising edges
  logic [pdg_pkg::FRAME_BITS-1:0] sh_q;
  logic [pdg_pkg::CNT_W-1:0]      bit_q;
  logic                           mode_dac_q;
  logic [pdg_pkg::FRAME_BITS-1:0] frame_q;
  logic                           frame_dac_q;
  logic                           frame_tgl_q;
  logic                           frame_open_q;
  pdg_pkg::pdg_state_type         lstate_q;
  logic [pdg_pkg::DATA_W-1:0]     rd_shadow_q;
  logic [pdg_pkg::FRAME_BITS-1:0] sh_next;

  // the clock stops outside frames, so the frame is closed by the
  // next first edge after cs returns high, and the toggle tells clk_i
  assign sh_next = {sh_q[pdg_pkg::FRAME_BITS-2:0], din_i};

  // frame shifter and state
  always_ff @(posedge sclk_i) begin
    if (cs_n_i) begin
      lstate_q <= pdg_pkg::PDG_IDLE;
      bit_q    <= '0;
      sh_q     <= '0;
    end else begin
      case (lstate_q)
        pdg_pkg::PDG_IDLE: begin
          mode_dac_q <= dac_sel_i;
          sh_q       <= sh_next;
          bit_q      <= pdg_pkg::CNT_W'(1);
          lstate_q   <= pdg_pkg::PDG_SHFT;
        end
        pdg_pkg::PDG_SHFT: begin
          sh_q  <= sh_next;
          bit_q <= bit_q + 1'b1;
          if (bit_q == pdg_pkg::CNT_W'(pdg_pkg::FRAME_BITS - 1)) begin
            lstate_q <= pdg_pkg::PDG_DONE;
          end
        end
        pdg_pkg::PDG_DONE: begin
          lstate_q <= pdg_pkg::PDG_DONE;        // extra bits dropped
        end
        default: begin
          lstate_q <= pdg_pkg::PDG_IDLE;
        end
      endcase
    end
  end

  // short sample frames stay left-justified: missing bits read as 0
  logic [pdg_pkg::FRAME_BITS-1:0] just_frame;
  always_comb begin
    just_frame = sh_q;
    if (lstate_q == pdg_pkg::PDG_SHFT) begin
      just_frame = sh_q << (pdg_pkg::CNT_W'(pdg_pkg::FRAME_BITS) - bit_q);
    end
  end

  // latch the frame on the first sclk edge seen with cs high
  // srst_i is quasi-static here: the host gives one sclk edge while
  // the system reset is still held, which clears the toggle
  always_ff @(posedge sclk_i) begin
    if (srst_i) begin
      frame_open_q <= 1'b0;
      frame_tgl_q  <= 1'b0;
    end else if (!cs_n_i) begin
      frame_open_q <= 1'b1;
    end else if (frame_open_q) begin
      frame_open_q <= 1'b0;
      frame_q      <= just_frame;
      frame_dac_q  <= mode_dac_q;
      frame_tgl_q  <= ~frame_tgl_q;             // end of frame on cs high
    end
  end

  // read data out, msb first, on falling edges
  logic [pdg_pkg::DATA_W-1:0] rd_sh_q;
  always_ff @(negedge sclk_i) begin
    if (cs_n_i) begin
      rd_sh_q <= '0;
    end else if (bit_q == pdg_pkg::CNT_W'(pdg_pkg::ADDR_LSB)) begin
      rd_sh_q <= rd_shadow_q;
    end else begin
      rd_sh_q <= {rd_sh_q[pdg_pkg::DATA_W-2:0], 1'b0};
    end
  end

  // ===========================================================
  // crossing: three-stage sync of frame toggle into clk_i
  logic [2:0] tgl_sync_q;
  logic       tgl_seen_q;
  logic [2:0] arm_q;
  // the link toggle keeps its level across a system reset, so no
  // event counts until the sync chain and tgl_seen_q hold it again;
  // without this a reset would replay the last frame
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arm_q <= '0;
    end else if (arm_q != pdg_pkg::SYNC_ARM) begin
      arm_q <= arm_q + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tgl_sync_q <= '0;
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl_q};
      if (tgl_sync_q[2] == tgl_sync_q[1]) begin
        tgl_seen_q <= tgl_sync_q[2];
      end
    end
  end
  logic frame_evt;
  assign frame_evt = (tgl_sync_q[2] == tgl_sync_q[1])
                     && (tgl_sync_q[2] != tgl_seen_q)
                     && (arm_q == pdg_pkg::SYNC_ARM);

  // ===========================================================
  // command registers on clk_i
  logic [pdg_pkg::DATA_W-1:0] first_block_enable_register_q;
  logic [pdg_pkg::DATA_W-1:0] gain_q;
  logic [pdg_pkg::DATA_W-1:0] first_control_register_q;
  logic [pdg_pkg::ADDR_W-1:0] frm_addr;
  logic                       frm_rd;
  assign frm_addr = frame_q[pdg_pkg::ADDR_MSB:pdg_pkg::ADDR_LSB];
  assign frm_rd   = frame_q[pdg_pkg::CMD_RD_BIT];

  // register read decode, used for the shadow and for future ports
  function automatic logic [7:0] reg_read(input logic [6:0] a,
                                          input logic [7:0] e,
                                          input logic [7:0] g,
                                          input logic [7:0] c);
    case (a)
      pdg_pkg::ADDR_FIRST_BLOCK_ENABLE_REGISTER:  reg_read = e;
      pdg_pkg::ADDR_GAIN:     reg_read = g;
      pdg_pkg::ADDR_FIRST_CONTROL_REGISTER: reg_read = c;
      default:                reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // frame data is stable while the toggle settles, so it is safe to read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      first_block_enable_register_q  <= pdg_pkg::FIRST_BLOCK_ENABLE_REGISTER_RST;
      gain_q     <= pdg_pkg::GAIN_RST;
      first_control_register_q <= pdg_pkg::FIRST_CONTROL_REGISTER_RST;
    end else if (frame_evt && !frame_dac_q && !frm_rd) begin
      case (frm_addr)
        pdg_pkg::ADDR_FIRST_BLOCK_ENABLE_REGISTER:  first_block_enable_register_q  <= frame_q[7:0];
        pdg_pkg::ADDR_GAIN:     gain_q     <= frame_q[7:0];
        pdg_pkg::ADDR_FIRST_CONTROL_REGISTER: first_control_register_q <= frame_q[7:0];
        default:                first_block_enable_register_q  <= first_block_enable_register_q;
      endcase
    end
  end

  // read shadow: register at the last read frame's address, returned on the next frame
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_shadow_q <= '0;
    end else if (frame_evt && !frame_dac_q && frm_rd) begin
      rd_shadow_q <= reg_read(frm_addr, first_block_enable_register_q, gain_q, first_control_register_q);
    end
  end

  // dout drives only inside a non-dac frame
  assign dout_o    = rd_sh_q[pdg_pkg::DATA_W-1];
  assign dout_oe_o = !cs_n_i && !mode_dac_q;

  // ===========================================================
  // sample path: frame bits 15:6 into fifo, then dac output
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [SAMPLE_W-1:0] fifo_out_data;
  logic [SAMPLE_W-1:0] dac_q;
  logic                upd_q;
  logic                drop_q;

  assign fifo_in_valid = frame_evt && frame_dac_q;

  pdg_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (frame_q[pdg_pkg::SAMPLE_MSB:pdg_pkg::SAMPLE_LSB]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (dac_ready_i),
    .out_data_o  (fifo_out_data)
  );

  // dac register moves only on a transferred sample, else holds
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dac_q <= pdg_pkg::SAMPLE_RST;
      upd_q <= 1'b0;
    end else begin
      upd_q <= fifo_out_valid && dac_ready_i;
      if (fifo_out_valid && dac_ready_i) begin
        dac_q <= fifo_out_data;
      end
    end
  end

  // a sample arriving into a full fifo is lost; flag it for one cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= fifo_in_valid && !fifo_in_ready;
    end
  end

  assign dac_data_o    = dac_q;
  assign dac_update_o  = upd_q;
  assign sample_drop_o = drop_q;

  // dac mode needs the pin and the enable bit together
  logic [2:0] sel_sync_q;
  logic       sel_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_sync_q <= '0;
      sel_q      <= 1'b0;
    end else begin
      sel_sync_q <= {sel_sync_q[1:0], dac_sel_i};
      if (sel_sync_q[2] == sel_sync_q[1]) begin
        sel_q <= sel_sync_q[2];
      end
    end
  end
  assign dac_mode_o = sel_q && first_block_enable_register_q[pdg_pkg::EN1_DAC_BIT];

  // ===========================================================
  // gain and band settings
  assign front_gain_code_o = gain_q[pdg_pkg::FRONT_LSB +: pdg_pkg::GAIN_W];
  assign back_gain_code_o  = gain_q[pdg_pkg::BACK_LSB +: pdg_pkg::GAIN_W];
  assign front_attenuate_o = (front_gain_code_o < pdg_pkg::FRONT_UNITY);
  assign band_select_bit_o = first_control_register_q[pdg_pkg::BAND_BIT];

  // ===========================================================
  // two-wire transmitter: combinational gate, no clock so the
  // carrier edges pass with no sampling jitter
  assign ook_out_o = carrier_i & ~keying_i;
  assign ook_oe_o  = ~keying_i;
endmodule : pdg_dac_load
`default_nettype wire

//--- tb/pdg_dac_load_asserts.sv
// checker: port relations of the dac loader
`timescale 1ns/1ps
`default_nettype none
module pdg_dac_load_asserts #(
  parameter int unsigned SAMPLE_W = 10
) (
  input wire logic                clk_i,
  input wire logic                srst_i,
  input wire logic                cs_n_i,
  input wire logic                dac_sel_i,
  input wire logic                dac_ready_i,
  input wire logic                carrier_i,
  input wire logic                keying_i,
  input wire logic                ook_out_o,
  input wire logic                ook_oe_o,
  input wire logic                dout_oe_o,
  input wire logic [SAMPLE_W-1:0] dac_data_o,
  input wire logic                dac_update_o,
  input wire logic                dac_mode_o,
  input wire logic [1:0]          front_gain_code_o,
  input wire logic [1:0]          back_gain_code_o,
  input wire logic                front_attenuate_o,
  input wire logic                band_select_bit_o
);
  // ==========================================================
  // assertions, all in the system clock domain
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ook_follow_a: assert property (!keying_i |-> ook_oe_o && ook_out_o == carrier_i)
    else $error("transmitter not following carrier");
  ook_hiz_a: assert property (keying_i |-> !ook_oe_o)
    else $error("transmitter driving while keyed off");
  front_att_a: assert property (front_attenuate_o == (front_gain_code_o < 2'h2))
    else $error("attenuate flag wrong for front code");
  load_update_a: assert property ($changed(dac_data_o) |-> dac_update_o)
    else $error("sample load without update pulse");
  update_pulse_a: assert property (dac_update_o && !dac_ready_i |=> !dac_update_o)
    else $error("update pulse longer than one cycle");
  update_ready_a: assert property (dac_update_o |-> $past(dac_ready_i))
    else $error("update while downstream not ready");
  mode_pin_a: assert property ($rose(dac_mode_o) |-> $past(dac_sel_i, 3))
    else $error("dac mode without select pin");
  dout_cs_a: assert property (dout_oe_o |-> !cs_n_i)
    else $error("serial output driven while deselected");
  cfg_quiet_a: assert property ($changed({front_gain_code_o,
    back_gain_code_o, band_select_bit_o}) |-> cs_n_i)
    else $error("settings changed inside a frame");
endmodule : pdg_dac_load_asserts
bind pdg_dac_load pdg_dac_load_asserts #(.SAMPLE_W(SAMPLE_W)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .dac_sel_i(dac_sel_i),
  .dac_ready_i(dac_ready_i), .carrier_i(carrier_i), .keying_i(keying_i),
  .ook_out_o(ook_out_o), .ook_oe_o(ook_oe_o), .dout_oe_o(dout_oe_o),
  .dac_data_o(dac_data_o), .dac_update_o(dac_update_o),
  .dac_mode_o(dac_mode_o), .front_gain_code_o(front_gain_code_o),
  .back_gain_code_o(back_gain_code_o),
  .front_attenuate_o(front_attenuate_o),
  .band_select_bit_o(band_select_bit_o));
`default_nettype wire

//--- tb/pdg_host_model.sv
// partner: host processor driving the four-wire serial port
`timescale 1ns/1ps
`default_nettype none
module pdg_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  output logic dac_sel_o
);
  // ==========================================================
  // idle, then one sclk edge with cs high so the link clears itself
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    dac_sel_o = 1'b0;
    #7 sclk_o = 1'b1;
    #16 sclk_o = 1'b0;
  end
  // one frame at 32 ns sclk; clock stands still outside frames
  task automatic send(input logic [15:0] w, input logic [3:0] tail,
                      input logic lng, input logic sel);
    logic [19:0] bits;
    int          n;
    bits = {w, tail};
    n = lng ? 20 : 16;
    cs_n_o = 1'b0;
    #4 dac_sel_o = sel;
    for (int i = 0; i < n; i++) begin
      #4 din_o = bits[19-i];
      #12 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
    #4 din_o = ~din_o; // released line must not look valid
    cs_n_o = 1'b1;
    #12 sclk_o = 1'b1; // closing edge with cs high
    #16 sclk_o = 1'b0;
    dac_sel_o = 1'b0;
  endtask : send
  // select pin moved on its own, outside a frame
  task automatic set_sel(input logic s);
    dac_sel_o = s;
  endtask : set_sel
endmodule : pdg_host_model
`default_nettype wire

//--- tb/pdg_dac_load_tb.sv
// testbench: dac loader, config registers and ook transmitter
`timescale 1ns/1ps
`default_nettype none
module pdg_dac_load_tb;
  // ==========================================================
  // signals and counters
  logic       clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       dac_ready_i = 1'b1;
  logic       carrier_i = 1'b0;
  logic       keying_i = 1'b1;
  wire logic  sclk, cs_n, din, dac_sel;
  logic       dout_o, dout_oe_o, dac_update_o, dac_mode_o, sample_drop_o;
  logic       front_attenuate_o, band_select_bit_o, ook_out_o, ook_oe_o;
  logic [1:0] front_gain_code_o, back_gain_code_o;
  logic [9:0] dac_data_o;
  logic [9:0] got_q[$];
  logic [9:0] exp_q[$];
  int         fail_count = 0;
  int         cmp_count = 0;
  int         drops = 0;
  integer     seed = 85843;
  always #12.5 clk_i = ~clk_i;
  pdg_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .dac_sel_o(dac_sel));
  pdg_dac_load dut (.clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .dac_sel_i(dac_sel), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .dac_data_o(dac_data_o),
    .dac_update_o(dac_update_o), .dac_ready_i(dac_ready_i),
    .dac_mode_o(dac_mode_o), .front_gain_code_o(front_gain_code_o),
    .back_gain_code_o(back_gain_code_o),
    .front_attenuate_o(front_attenuate_o),
    .band_select_bit_o(band_select_bit_o), .carrier_i(carrier_i),
    .keying_i(keying_i), .ook_out_o(ook_out_o), .ook_oe_o(ook_oe_o),
    .sample_drop_o(sample_drop_o));
  // collect every dac update and every dropped sample
  always @(posedge clk_i) begin
    if (dac_update_o === 1'b1) got_q.push_back(dac_data_o);
    if (sample_drop_o === 1'b1) drops++;
  end
  // ==========================================================
  // helpers
  function automatic logic [9:0] sample_of(input logic [15:0] w);
    return w[15:6];
  endfunction : sample_of
  function automatic logic [15:0] exp_cfg(input logic [1:0] f,
                                          input logic [1:0] b,
                                          input logic       bd);
    return 16'({f, b, bd, f < 2'h2});
  endfunction : exp_cfg
  function automatic logic [15:0] cfg_now();
    return 16'({front_gain_code_o, back_gain_code_o, band_select_bit_o,
                front_attenuate_o});
  endfunction : cfg_now
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : wait_clk
  // bounded wait for n collected updates
  task automatic wait_got(input int n);
    int t;
    t = 0;
    while (got_q.size() < n && t < 300) begin
      wait_clk(1);
      t++;
    end
    if (got_q.size() < n) begin
      fail_count++;
      $display("Error update count expected %0d seen %0d", n, got_q.size());
      summarize();
    end
  endtask : wait_got
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.send({1'b0, a, d}, 4'h0, 1'b0, 1'b0);
    wait_clk(10);
  endtask : wr
  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] w;
    logic [7:0]  r;
    wait_clk(8);
    srst_i = 1'b0;
    wait_clk(2);
    check("reset cfg", cfg_now(), exp_cfg(2'h0, 2'h0, 1'b0));
    check("reset dac", 16'(dac_data_o), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      wr(pdg_pkg::ADDR_GAIN, {r[7:4], 2'(3 - i), 2'(i)});
      check("gain", cfg_now(), exp_cfg(2'(i), 2'(3 - i), 1'b0));
    end
    for (int b = 0; b < 2; b++) begin
      r = 8'($random(seed));
      wr(pdg_pkg::ADDR_FIRST_CONTROL_REGISTER, {r[7:4], 1'(b), r[2:0]});
      check("band", cfg_now(), exp_cfg(2'h3, 2'h0, 1'(b)));
    end
    wr(7'h7f, 8'hff);
    check("unmapped", cfg_now(), exp_cfg(2'h3, 2'h0, 1'b1));
    for (int e = 0; e < 2; e++) begin
      wr(pdg_pkg::ADDR_FIRST_BLOCK_ENABLE_REGISTER, 8'(e << 5));
      host.set_sel(1'b1);
      wait_clk(8);
      check("mode", 16'(dac_mode_o), 16'(e));
      host.set_sel(1'b0);
      wait_clk(8);
    end
    // first frame is 20 bits long, extra bits must vanish
    for (int k = 0; k < 6; k++) begin
      w = 16'($random(seed));
      r = 8'($random(seed));
      host.send(w, r[3:0], k == 0, 1'b1);
      wait_got(k + 1);
      check("sample", 16'(got_q[k]), 16'(sample_of(w)));
      wait_clk(4);
    end
    check("cfg kept", cfg_now(), exp_cfg(2'h3, 2'h0, 1'b1));
    // stall downstream, overfill the four-word fifo, then drain
    dac_ready_i = 1'b0;
    got_q.delete();
    for (int k = 0; k < 5; k++) begin
      w = 16'($random(seed));
      if (k < 4) exp_q.push_back(sample_of(w));
      host.send(w, 4'h0, 1'b0, 1'b1);
      wait_clk(8);
    end
    check("drop", 16'(drops), 16'h0001);
    check("held", 16'(got_q.size()), 16'h0000);
    dac_ready_i = 1'b1;
    wait_got(4);
    for (int k = 0; k < 4; k++) begin
      check("drain", 16'(got_q[k]), 16'(exp_q[k]));
    end
    wr(pdg_pkg::ADDR_GAIN, 8'h05);
    check("dac hold", 16'(dac_data_o), 16'(exp_q[3]));
    check("cfg", cfg_now(), exp_cfg(2'h1, 2'h1, 1'b1));
    // second reset in mid-run: settings clear, no frame is replayed
    srst_i = 1'b1;
    wait_clk(4);
    srst_i = 1'b0;
    wait_clk(10);
    check("rerst cfg", cfg_now(), exp_cfg(2'h0, 2'h0, 1'b0));
    check("rerst dac", 16'(dac_data_o), 16'h0000);
    check("rerst mode", 16'(dac_mode_o), 16'h0000);
    repeat (32) begin
      wait_clk(1);
      carrier_i = 1'($random(seed));
      keying_i = 1'($random(seed));
      #5;
      check("ook oe", 16'(ook_oe_o), 16'(!keying_i));
      if (!keying_i) check("ook", 16'(ook_out_o), 16'(carrier_i));
    end
    summarize();
  end
endmodule : pdg_dac_load_tb
`default_nettype wire
